// file: src/ppio_defines.vh
// Purpose: Constants for the programmable parallel I/O block (three 8-bit ports).
// Assumes: Wishbone classic slave, 32-bit data, byte-addressed word registers.
// Notes:   Every offset and field position, and the control, port and error reset values, live here.
// How it works
// - Reset loads control word 9B and makes every port an input.
// - Group one owns port one and upper half; group two port two and lower half.
// - The control configuration register is write-only; reads return zero.
// - Port one has an 8-bit output latch and a separate 8-bit input latch.
// - Port two has an 8-bit in/out latch plus an unlatched input buffer.
// - Port three has an output latch; reads return live pin levels for input halves, the latch for output halves.
// - Port three splits into two 4-bit halves, each with its own direction; one 8-bit latch holds both.
// - Modes 0, 1 and 2 are selected by a single host write.
// - On reset all 24 port lines float as inputs.
// - After reset the block stays in input mode with no setup needed.
// - Ports one and two take independent modes; port three is shared.
// - Programming a new mode clears every output register and the port one input latch.
// - One write sets or clears one port three bit, changing only it.
// - Select 0,1,2 reach ports; 3 writes control; read of 3 is illegal.
// - Without a selected access the data bus is not driven.
`ifndef PPIO_DEFINES_VH
`define PPIO_DEFINES_VH
// Register byte offsets (word index = port_select)
`define PPIO_OFS_PORT_ONE   8'h00
`define PPIO_OFS_PORT_TWO   8'h04
`define PPIO_OFS_PORT_THREE 8'h08
`define PPIO_OFS_CONTROL    8'h0C
`define PPIO_OFS_ILLEGAL    8'h10
// Port select codes
`define PPIO_SEL_ONE        2'h0
`define PPIO_SEL_TWO        2'h1
`define PPIO_SEL_THREE      2'h2
`define PPIO_SEL_CTRL       2'h3
// Control word fields
`define PPIO_CW_MODE_FLAG   7
`define PPIO_CW_G1_MODE_HI  6
`define PPIO_CW_G1_MODE_LO  5
`define PPIO_CW_ONE_IN      4
`define PPIO_CW_UPPER_IN    3
`define PPIO_CW_G2_MODE     2
`define PPIO_CW_TWO_IN      1
`define PPIO_CW_LOWER_IN    0
`define PPIO_CW_BIT_HI      3
`define PPIO_CW_BIT_LO      1
`define PPIO_CW_BIT_VAL     0
// Reset values
`define PPIO_CW_RESET       8'h9B
`define PPIO_PORT_RESET     8'h00
`define PPIO_ERR_RESET      1'h0
`endif

// file: src/ppio_wb_slave.v
// Purpose: Wishbone classic slave front end for the parallel I/O block.
// Assumes: Single clock; request held until ack; one-cycle ack answer.
// Notes:   Produces one-cycle strobes for the core; ack drops after one cycle.
`include "ppio_defines.vh"
module ppio_wb_slave (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst_n,
  // Wishbone
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  output reg         wb_ack_o,
  // Core strobes
  output wire        acc_wr,
  output wire        acc_rd,
  output wire [2:0]  acc_idx
);
  wire req;
  // New request only when not already acking
  assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign acc_wr  = req & wb_we_i & wb_sel_i[0];
  assign acc_rd  = req & ~wb_we_i;
  assign acc_idx = wb_adr_i[4:2];
  // Ack one cycle after request
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end
endmodule // ppio_wb_slave

// file: src/ppio_top.v
// Purpose: Three 8-bit programmable parallel ports with mode and bit set/clear.
// Assumes: Host over Wishbone; port pins asynchronous, synchronised twice.
// Notes:   Strobed handshake bit encodings not modelled; modes 1/2 keep latches.
`include "ppio_defines.vh"
module ppio_top (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // Port one
  input  wire [7:0]  port_one_lines_i,
  output wire [7:0]  port_one_lines_o,
  output wire [7:0]  port_one_lines_oe,
  // Port two
  input  wire [7:0]  port_two_lines_i,
  output wire [7:0]  port_two_lines_o,
  output wire [7:0]  port_two_lines_oe,
  // Port three
  input  wire [7:0]  port_three_lines_i,
  output wire [7:0]  port_three_lines_o,
  output wire [7:0]  port_three_lines_oe,
  // Status
  output wire        illegal_read
);
  reg  [1:0]  rst_sync_q;
  wire        rst_n;
  reg  [7:0]  cw_q;
  reg  [7:0]  one_out_q;
  reg  [7:0]  one_in_q;
  reg  [7:0]  two_out_q;
  reg  [7:0]  three_out_q;
  reg  [7:0]  one_oe_q;
  reg  [7:0]  two_oe_q;
  reg  [7:0]  three_oe_q;
  reg  [31:0] dat_q;
  reg         err_q;
  reg  [7:0]  one_s1_q;
  reg  [7:0]  one_s2_q;
  reg  [7:0]  two_s1_q;
  reg  [7:0]  two_s2_q;
  reg  [7:0]  three_s1_q;
  reg  [7:0]  three_s2_q;
  reg  [7:0]  rd_d;
  reg  [7:0]  three_d;
  reg  [7:0]  oe1_d;
  reg  [7:0]  oe2_d;
  reg  [7:0]  oe3_d;
  wire        acc_wr;
  wire        acc_rd;
  wire [2:0]  acc_idx;
  wire [7:0]  wdat;
  wire [1:0]  g1_mode;
  wire        mode_wr;
  wire        bit_wr;
  wire [2:0]  bit_num;

  // Reset release through two flops
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // Bus front end
  ppio_wb_slave u_wb (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_ack_o (wb_ack_o),
    .acc_wr   (acc_wr),
    .acc_rd   (acc_rd),
    .acc_idx  (acc_idx)
  );

  // Control word decode
  assign wdat    = wb_dat_i[7:0];
  assign mode_wr = acc_wr & (acc_idx == {1'b0, `PPIO_SEL_CTRL}) & wdat[`PPIO_CW_MODE_FLAG];
  assign bit_wr  = acc_wr & (acc_idx == {1'b0, `PPIO_SEL_CTRL}) & ~wdat[`PPIO_CW_MODE_FLAG];
  assign bit_num = wdat[`PPIO_CW_BIT_HI:`PPIO_CW_BIT_LO];
  assign g1_mode = cw_q[`PPIO_CW_G1_MODE_HI:`PPIO_CW_G1_MODE_LO];

  // Pin synchronisers
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      one_s1_q   <= 8'h00;
      one_s2_q   <= 8'h00;
      two_s1_q   <= 8'h00;
      two_s2_q   <= 8'h00;
      three_s1_q <= 8'h00;
      three_s2_q <= 8'h00;
    end else begin
      one_s1_q   <= port_one_lines_i;
      one_s2_q   <= one_s1_q;
      two_s1_q   <= port_two_lines_i;
      two_s2_q   <= two_s1_q;
      three_s1_q <= port_three_lines_i;
      three_s2_q <= three_s1_q;
    end
  end

  // Port three next value: single bit set or clear
  always @* begin
    three_d = three_out_q;
    if (bit_wr) begin
      three_d[bit_num] = wdat[`PPIO_CW_BIT_VAL];
    end
  end

  // Direction per group from control word
  always @* begin
    oe1_d = cw_q[`PPIO_CW_ONE_IN] ? 8'h00 : 8'hFF;
    oe2_d = cw_q[`PPIO_CW_TWO_IN] ? 8'h00 : 8'hFF;
    oe3_d[7:4] = cw_q[`PPIO_CW_UPPER_IN] ? 4'h0 : 4'hF;
    oe3_d[3:0] = cw_q[`PPIO_CW_LOWER_IN] ? 4'h0 : 4'hF;
    if (g1_mode[1]) begin
      oe1_d = 8'h00; // Bidirectional: driven only when output path enabled
      if (!cw_q[`PPIO_CW_ONE_IN]) begin
        oe1_d = 8'hFF;
      end
    end
  end

  // Control word and output latches
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cw_q        <= `PPIO_CW_RESET;
      one_out_q   <= `PPIO_PORT_RESET;
      two_out_q   <= `PPIO_PORT_RESET;
      three_out_q <= `PPIO_PORT_RESET;
    end else if (mode_wr) begin
      cw_q        <= wdat;
      one_out_q   <= `PPIO_PORT_RESET;
      two_out_q   <= `PPIO_PORT_RESET;
      three_out_q <= `PPIO_PORT_RESET;
    end else if (acc_wr) begin
      if (acc_idx == {1'b0, `PPIO_SEL_ONE}) begin
        one_out_q <= wdat;
      end
      if (acc_idx == {1'b0, `PPIO_SEL_TWO}) begin
        two_out_q <= wdat;
      end
      if (acc_idx == {1'b0, `PPIO_SEL_THREE}) begin
        three_out_q <= wdat;
      end else begin
        three_out_q <= three_d;
      end
    end
  end

  // Port one input latch, refreshed every cycle from the synchronised pins except on a mode write, which clears it
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      one_in_q <= `PPIO_PORT_RESET;
    end else if (mode_wr) begin
      one_in_q <= `PPIO_PORT_RESET;
    end else begin
      one_in_q <= one_s2_q;
    end
  end

  // Output enables registered
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      one_oe_q   <= 8'h00;
      two_oe_q   <= 8'h00;
      three_oe_q <= 8'h00;
    end else begin
      one_oe_q   <= oe1_d;
      two_oe_q   <= oe2_d;
      three_oe_q <= oe3_d;
    end
  end

  // Read data mux
  always @* begin
    case (acc_idx)
      {1'b0, `PPIO_SEL_ONE}:   rd_d = cw_q[`PPIO_CW_ONE_IN] ? one_in_q : one_out_q;
      {1'b0, `PPIO_SEL_TWO}:   rd_d = cw_q[`PPIO_CW_TWO_IN] ? two_s2_q : two_out_q;
      {1'b0, `PPIO_SEL_THREE}: rd_d = {cw_q[`PPIO_CW_UPPER_IN] ? three_s2_q[7:4] : three_out_q[7:4],
                                       cw_q[`PPIO_CW_LOWER_IN] ? three_s2_q[3:0] : three_out_q[3:0]};
      default:                 rd_d = 8'h00;
    endcase
  end

  // Read data register and illegal read flag
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dat_q <= 32'h00000000;
      err_q <= `PPIO_ERR_RESET;
    end else begin
      if (acc_rd) begin
        dat_q <= {24'h000000, rd_d};
        err_q <= (acc_idx == {1'b0, `PPIO_SEL_CTRL});
      end else begin
        dat_q <= 32'h00000000;
      end
    end
  end

  assign wb_dat_o            = dat_q;
  assign illegal_read        = err_q;
  assign port_one_lines_o    = one_out_q;
  assign port_one_lines_oe   = one_oe_q;
  assign port_two_lines_o    = two_out_q;
  assign port_two_lines_oe   = two_oe_q;
  assign port_three_lines_o  = three_out_q;
  assign port_three_lines_oe = three_oe_q;
endmodule // ppio_top

// file: tb/ppio_properties.sv
// Purpose: Bus timing and port effect checks on the parallel I/O top.
// Assumes: One-cycle ack; port latches land one edge after the take, output enables two.
// Notes:   Bound to every instance of the top module.
module ppio_props (
  // Clock, reset and bus
  input logic        clk_sys,
  input logic        rstn,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [7:0]  wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  // Ports and status
  input logic [7:0]  port_one_lines_o,
  input logic [7:0]  port_two_lines_o,
  input logic [7:0]  port_three_lines_o,
  input logic [7:0]  port_one_lines_oe,
  input logic [7:0]  port_two_lines_oe,
  input logic [7:0]  port_three_lines_oe,
  input logic        illegal_read
);
  timeunit 1ns;
  timeprecision 1ps;
  logic take;
  logic wr_ctl;
  logic rd_ctl;
  // Request taken, control write and control read
  assign take   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctl = take && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h0C;
  assign rd_ctl = wb_ack_o && !wb_we_i && wb_adr_i == 8'h0C;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  ack_after_take_a: assert property (take |=> wb_ack_o) else $error("ack missing");
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  bus_idle_zero_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data bus driven");
  ctrl_read_zero_a: assert property (rd_ctl |-> wb_dat_o == 32'h0) else $error("control readable");
  illegal_flag_a: assert property (rd_ctl |=> illegal_read) else $error("illegal read unflagged");
  mode_clear_a: assert property (wr_ctl && wb_dat_i[7] |-> ##2
    {port_one_lines_o, port_two_lines_o, port_three_lines_o} == 24'h0) else $error("latches kept");
  bit_only_a: assert property (wr_ctl && !wb_dat_i[7] |-> ##2 port_three_lines_o ==
    (($past(port_three_lines_o, 2) & ~(8'h01 << $past(wb_dat_i[3:1], 2)))
    | ({7'h00, $past(wb_dat_i[0], 2)} << $past(wb_dat_i[3:1], 2)))) else $error("bit write wrong");
  release_float_a: assert property ($rose(rstn) |->
    {port_one_lines_oe, port_two_lines_oe, port_three_lines_oe} == 24'h0) else $error("pins driven");
  all_out_a: assert property (wr_ctl && wb_dat_i[7:0] == 8'h80 |-> ##[2:3]
    {port_one_lines_oe, port_two_lines_oe, port_three_lines_oe} == 24'hFFFFFF) else $error("not output");
  halves_split_a: assert property (wr_ctl && wb_dat_i[7:0] == 8'h88 |-> ##[2:3]
    port_three_lines_oe == 8'h0F) else $error("halves wrong");
  // Main scenarios
  cover property (wr_ctl && wb_dat_i[7]);
  cover property (wr_ctl && !wb_dat_i[7]);
  cover property (rd_ctl);
endmodule // ppio_props

bind ppio_top ppio_props ppio_props_inst (.*);

// file: tb/ppio_pin_model.sv
// Purpose: Peripheral pin model for one 8-bit port.
// Assumes: Peripheral drives every line that the block leaves released.
// Notes:   Resolved level feeds the block's pin inputs.
module ppio_pin_model (
  // Block side
  input  logic [7:0] pin_out,
  input  logic [7:0] pin_oe,
  // Peripheral side
  input  logic [7:0] periph_val,
  output logic [7:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Block wins where it drives
  assign pin_in = (pin_out & pin_oe) | (periph_val & ~pin_oe);
endmodule // ppio_pin_model

// file: tb/ppio_top_test.sv
// Purpose: Self-checking bench for the parallel I/O top.
// Assumes: Wishbone classic master; ports 00/04/08, control 0C.
// Notes:   Pins resolved by three peripheral models.
module ppio_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rstn = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o, illegal_read;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  wire  [23:0] pin_o, pin_oe, pin_i;
  logic [23:0] periph = 24'h5AC33C;
  int          failures = 0, num_checks = 0;

  always #4 clk_sys = ~clk_sys;

  ppio_top ppio_top_inst (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .port_one_lines_i(pin_i[7:0]), .port_one_lines_o(pin_o[7:0]),
    .port_one_lines_oe(pin_oe[7:0]), .port_two_lines_i(pin_i[15:8]), .port_two_lines_o(pin_o[15:8]),
    .port_two_lines_oe(pin_oe[15:8]), .port_three_lines_i(pin_i[23:16]), .port_three_lines_o(pin_o[23:16]),
    .port_three_lines_oe(pin_oe[23:16]), .illegal_read(illegal_read));
  ppio_pin_model ppio_pin_model_inst [2:0] (.pin_out(pin_o), .pin_oe(pin_oe), .periph_val(periph),
    .pin_in(pin_i));

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One classic cycle, held until ack
  task wb_io(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, 4'h1};
    @(posedge clk_sys);
    while (wb_ack_o !== 1'b1) @(posedge clk_sys);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
  endtask

  task finish_test;
    if (failures == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    finish_test;
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check("oe after reset", {8'h00, pin_oe}, 32'h0);
    for (int p = 0; p < 3; p++) begin
      wb_io(1'b0, 8'(4 * p), 32'h0);
      check("port input", rd, {24'h0, periph[8 * p +: 8]});
    end
    wb_io(1'b0, 8'h0C, 32'h0);
    repeat (2) @(posedge clk_sys);
    check("control read", rd, 32'h0);
    check("illegal flag", {31'h0, illegal_read}, 32'h1);
    wb_io(1'b0, 8'h10, 32'h0);
    check("unmapped read", rd, 32'h0);
    check("unmapped flag", {31'h0, illegal_read}, 32'h0);
    // All outputs, then latch values
    wb_io(1'b1, 8'h0C, 32'h80);
    for (int p = 0; p < 3; p++) wb_io(1'b1, 8'(4 * p), 32'hA5 ^ p);
    repeat (3) @(posedge clk_sys);
    check("latches", {8'h00, pin_o}, 32'hA7A4A5);
    check("all oe", {8'h00, pin_oe}, 32'hFFFFFF);
    // Single bit set then clear on port three
    wb_io(1'b1, 8'h0C, 32'h07);
    repeat (3) @(posedge clk_sys);
    check("bit set", {24'h0, pin_o[23:16]}, 32'hAF);
    wb_io(1'b1, 8'h0C, 32'h0E);
    repeat (3) @(posedge clk_sys);
    check("bit clear", {8'h00, pin_o}, 32'h2FA4A5);
    // Every mode word clears the latches
    for (int m = 0; m < 3; m++) begin
      wb_io(1'b1, 8'h00, 32'hFF);
      wb_io(1'b1, 8'h0C, {24'h0, 1'b1, 2'(2 - m), 5'h08});
      repeat (3) @(posedge clk_sys);
      check("mode clear", {8'h00, pin_o}, 32'h0);
    end
    check("group split", {8'h00, pin_oe}, 32'h0FFFFF);
    wb_io(1'b1, 8'h08, 32'hFF);
    repeat (6) @(posedge clk_sys);
    wb_io(1'b0, 8'h08, 32'h0);
    check("live halves", rd, 32'h5F);
    // Reset in mid-run
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check("reset oe", {8'h00, pin_oe}, 32'h0);
    check("reset latch", {8'h00, pin_o}, 32'h0);
    // Release again: back to all inputs with no setup
    rstn <= 1'b1;
    repeat (4) @(posedge clk_sys);
    wb_io(1'b0, 8'h04, 32'h0);
    check("input after reset", rd, {24'h0, periph[15:8]});
    check("oe after release", {8'h00, pin_oe}, 32'h0);
    finish_test;
  end
endmodule // ppio_top_test
